// ### rtl/rsx_pkg.sv
package rsx_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int ADDR_BYTES = 4 * (1 << ADDR_W);

  // Register byte addresses on the bus.
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_ACC = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_WDOG = 12'h00C;
  localparam logic [11:0] OFS_FILE = 12'h400;

  // Command register fields.
  localparam int CMD_LIT_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_DEST_BIT = 15;
  localparam int CMD_OP_LSB = 16;

  // Status register bit positions.
  localparam int ST_CARRY = 0;
  localparam int ST_HALF = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_SLEEP = 5;
  localparam int ST_WAKE = 6;

  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [7:0] RST_WDOG = 8'h00;

  typedef enum logic [1:0] {
    OP_ROT_RIGHT,
    OP_ROT_LEFT,
    OP_LIT_SUB,
    OP_SLEEP
  } op_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### rtl/rsx_alu.sv
`timescale 1ns/1ns
module rsx_alu
  import rsx_pkg::*;
(
  // Operation and operands.
  input wire logic [1:0] op,
  input wire logic [7:0] operand,
  input wire logic [7:0] acc,
  input wire logic carry_in,
  // Result and flags.
  output logic [7:0] result,
  output logic carry_out,
  output logic half_out,
  output logic zero_out
);

  logic [8:0] diff;
  logic [4:0] low_diff;

  always_comb begin
    diff = {1'b0, operand} + {1'b0, ~acc} + 9'h001;
    low_diff = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    result = operand;
    carry_out = carry_in;
    half_out = 1'b0;
    zero_out = 1'b0;
    case (op)
      OP_ROT_RIGHT: begin
        result = {carry_in, operand[7:1]};
        carry_out = operand[0];
      end
      OP_ROT_LEFT: begin
        result = {operand[6:0], carry_in};
        carry_out = operand[7];
      end
      OP_LIT_SUB: begin
        // Carry and half-carry are the inverted borrows of the subtraction.
        result = diff[7:0];
        carry_out = diff[8];
        half_out = low_diff[4];
        zero_out = (diff[7:0] == 8'h00);
      end
      default: begin
        result = operand;
      end
    endcase
  end

endmodule

// ### rtl/rsx_core.sv
`timescale 1ns/1ns
module rsx_core
  import rsx_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Wake-up event from outside the core.
  input wire logic WAKE,
  // AXI4-Lite write address and data.
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response.
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read.
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Core state.
  output logic SLEEPING
);

  typedef struct packed {
    logic [127:0][7:0] file;
    logic [7:0] acc;
    logic carry;
    logic half;
    logic zero;
    logic power_down_flag;
    logic timeout_flag;
    logic sleeping;
    logic [7:0] watchdog_counter;
    logic [7:0] prescale;
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
  } state_t;

  state_t s;
  state_t next_s;

  logic [1:0] op;
  logic [7:0] operand;
  logic [7:0] result;
  logic carry_out;
  logic half_out;
  logic zero_out;
  logic [6:0] f_addr;
  logic dest;
  logic [31:0] cmd_word;
  logic issue;

  // The command is decoded from the held word or the word taken in this cycle, never from
  // the next state, so the next-state logic has no feedback path through the decoder.
  always_comb begin
    cmd_word = s.w_held ? s.w_data : WDATA;
    op = cmd_word[CMD_OP_LSB +: 2];
    f_addr = cmd_word[CMD_ADDR_LSB +: ADDR_W];
    dest = cmd_word[CMD_DEST_BIT];
    operand = (op == OP_LIT_SUB) ? cmd_word[CMD_LIT_LSB +: 8] : s.file[f_addr];
  end

  rsx_alu u_alu (
    .op(op),
    .operand(operand),
    .acc(s.acc),
    .carry_in(s.carry),
    .result(result),
    .carry_out(carry_out),
    .half_out(half_out),
    .zero_out(zero_out)
  );

  always_comb begin
    next_s = s;
    issue = 1'b0;
    if (WAKE) begin
      next_s.sleeping = 1'b0;
    end
    if (AWVALID && !s.aw_held && !s.bvalid) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = AWADDR;
    end
    if (WVALID && !s.w_held && !s.bvalid) begin
      next_s.w_held = 1'b1;
      next_s.w_data = WDATA;
      next_s.w_strb = WSTRB;
    end
    if (next_s.aw_held && next_s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (next_s.aw_addr[11:2] == OFS_CMD[11:2]) begin
        // Commands are refused while asleep.
        issue = !s.sleeping;
        if (s.sleeping) begin
          next_s.bresp = RESP_SLVERR;
        end
      end else if (next_s.aw_addr[11:2] == OFS_ACC[11:2]) begin
        if (next_s.w_strb[0]) begin
          next_s.acc = next_s.w_data[7:0];
        end
      end else if (next_s.aw_addr[11:9] == OFS_FILE[11:9]) begin
        if (next_s.w_strb[0]) begin
          next_s.file[next_s.aw_addr[8:2]] = next_s.w_data[7:0];
        end
      end else begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    if (issue) begin
      case (op)
        OP_ROT_RIGHT, OP_ROT_LEFT: begin
          next_s.carry = carry_out;
          if (dest) begin
            next_s.file[f_addr] = result;
          end else begin
            next_s.acc = result;
          end
        end
        OP_LIT_SUB: begin
          next_s.acc = result;
          next_s.carry = carry_out;
          next_s.half = half_out;
          next_s.zero = zero_out;
        end
        default: begin
          next_s.power_down_flag = 1'b0;
          next_s.timeout_flag = 1'b1;
          next_s.watchdog_counter = RST_WDOG;
          next_s.prescale = RST_PRESCALE;
          next_s.sleeping = 1'b1;
        end
      endcase
    end else if (!s.sleeping) begin
      // The watchdog counts on the prescaler wrap while the oscillator runs.
      next_s.prescale = s.prescale + 8'h01;
      if (s.prescale == 8'hFF) begin
        next_s.watchdog_counter = s.watchdog_counter + 8'h01;
      end
    end
    if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end else if (ARVALID && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (ARADDR[11:2] == OFS_ACC[11:2]) begin
        next_s.rdata[7:0] = s.acc;
      end else if (ARADDR[11:2] == OFS_STAT[11:2]) begin
        next_s.rdata[ST_CARRY] = s.carry;
        next_s.rdata[ST_HALF] = s.half;
        next_s.rdata[ST_ZERO] = s.zero;
        next_s.rdata[ST_PD] = s.power_down_flag;
        next_s.rdata[ST_TO] = s.timeout_flag;
        next_s.rdata[ST_SLEEP] = s.sleeping;
      end else if (ARADDR[11:2] == OFS_WDOG[11:2]) begin
        next_s.rdata[15:0] = {s.prescale, s.watchdog_counter};
      end else if (ARADDR[11:9] == OFS_FILE[11:9]) begin
        next_s.rdata[7:0] = s.file[ARADDR[8:2]];
      end else if (ARADDR[11:2] != OFS_CMD[11:2]) begin
        next_s.rresp = RESP_SLVERR;
      end
    end
    if (SYS_RST) begin
      next_s = '0;
      next_s.acc = RST_ACC;
      next_s.power_down_flag = 1'b1;
      next_s.timeout_flag = 1'b1;
    end
    // Ready flags are registered so that every bus output leaves a flip-flop.
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge CLK) begin
    s <= next_s;
  end

  assign AWREADY = s.awready;
  assign WREADY = s.wready;
  assign ARREADY = s.arready;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign RVALID = s.rvalid;
  assign RDATA = s.rdata;
  assign RRESP = s.rresp;
  assign SLEEPING = s.sleeping;

  sequence q_sleep_cmd;
    issue && op == OP_SLEEP;
  endsequence

  property p_sleep_flags;
    @(posedge CLK) disable iff (SYS_RST) q_sleep_cmd |=> !s.power_down_flag && s.timeout_flag;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

  property p_sleep_keeps_alu;
    @(posedge CLK) disable iff (SYS_RST) q_sleep_cmd |=> $stable(s.carry) && $stable(s.zero);
  endproperty
  a_sleep_keeps_alu: assert property (p_sleep_keeps_alu) else $error("sleep touched flags");

  property p_sleep_wdog;
    @(posedge CLK) disable iff (SYS_RST)
      q_sleep_cmd |=> s.watchdog_counter == 8'h00 && s.prescale == 8'h00;
  endproperty
  a_sleep_wdog: assert property (p_sleep_wdog) else $error("watchdog not cleared");

  property p_sleep_halt;
    @(posedge CLK) disable iff (SYS_RST) q_sleep_cmd ##1 !WAKE |=> SLEEPING && $stable(s.acc);
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("core not halted");

  property p_rrf;
    @(posedge CLK) disable iff (SYS_RST) issue && op == OP_ROT_RIGHT && !dest
      |=> s.acc == {$past(s.carry), $past(operand[7:1])} && s.carry == $past(operand[0])
        && $stable(s.half) && $stable(s.zero);
  endproperty
  a_rrf: assert property (p_rrf) else $error("rotate right wrong");

  property p_rlf;
    @(posedge CLK) disable iff (SYS_RST) issue && op == OP_ROT_LEFT && !dest
      |=> s.acc == {$past(operand[6:0]), $past(s.carry)} && s.carry == $past(operand[7]);
  endproperty
  a_rlf: assert property (p_rlf) else $error("rotate left wrong");

  property p_rot_file;
    @(posedge CLK) disable iff (SYS_RST) issue && op != OP_LIT_SUB && op != OP_SLEEP && dest
      |=> s.file[$past(f_addr)] == (($past(op) == OP_ROT_RIGHT)
        ? {$past(s.carry), $past(operand[7:1])} : {$past(operand[6:0]), $past(s.carry)})
        && $stable(s.acc);
  endproperty
  a_rot_file: assert property (p_rot_file) else $error("rotate routing wrong");

  property p_sub;
    @(posedge CLK) disable iff (SYS_RST) issue && op == OP_LIT_SUB
      |=> s.acc == 8'($past(operand) - $past(s.acc)) && s.zero == (s.acc == 8'h00)
        && s.carry == ($past(operand) >= $past(s.acc))
        && s.half == ($past(operand[3:0]) >= $past(s.acc[3:0]));
  endproperty
  a_sub: assert property (p_sub) else $error("subtract wrong");

endmodule

// ### dv/test_rsx_core.sv
`timescale 1ns/1ns
module test_rsx_core
  import rsx_pkg::*;
();

  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic WAKE = 1'b0;
  logic [11:0] AWADDR = 12'h000;
  logic AWVALID = 1'b0;
  logic AWREADY;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'hF;
  logic WVALID = 1'b0;
  logic WREADY;
  logic [1:0] BRESP;
  logic BVALID;
  logic BREADY = 1'b0;
  logic [11:0] ARADDR = 12'h000;
  logic ARVALID = 1'b0;
  logic ARREADY;
  logic [31:0] RDATA;
  logic [1:0] RRESP;
  logic RVALID;
  logic RREADY = 1'b0;
  logic SLEEPING;
  int bad_count = 0;
  int num_checks = 0;

  rsx_core dut (
    .CLK(CLK), .SYS_RST(SYS_RST), .WAKE(WAKE),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .SLEEPING(SLEEPING)
  );

  always #25 CLK = ~CLK;

  task automatic stop_test;
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Outputs are sampled at the falling edge, where they are settled.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b, done;
    logic [1:0] r;
    done = 1'b0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!done) begin
      @(negedge CLK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      b = BVALID;
      r = BRESP;
      @(posedge CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      if (b) begin
        BREADY <= 1'b0;
        done = 1'b1;
      end
    end
    // An edge passes so that the next call never drives a ready twice in one step.
    @(posedge CLK);
    chk("write response", {30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er,
                    input string what);
    logic ar, done;
    logic [31:0] d;
    logic [1:0] r;
    done = 1'b0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!done) begin
      @(negedge CLK);
      ar = ARVALID && ARREADY;
      done = RVALID;
      d = RDATA;
      r = RRESP;
      @(posedge CLK);
      if (ar) ARVALID <= 1'b0;
      if (done) RREADY <= 1'b0;
    end
    @(posedge CLK);
    chk(what, d, ed);
    chk("read response", {30'h0, r}, {30'h0, er});
  endtask

  function automatic logic [31:0] cmd(input logic [1:0] op, input logic dest,
                                      input logic [6:0] fa, input logic [7:0] lit);
    return {14'h0, op, dest, fa, lit};
  endfunction

  function automatic logic [11:0] fofs(input int n);
    return OFS_FILE + 12'(4 * n);
  endfunction

  task automatic run_tests;
    repeat (5) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    rd(OFS_STAT, 32'h18, RESP_OKAY, "status after reset");
    rd(OFS_ACC, 32'h0, RESP_OKAY, "acc after reset");
    rd(12'h010, 32'h0, RESP_SLVERR, "unmapped read");
    wr(12'h010, 32'h5, RESP_SLVERR);
    // Difference of zero: no borrow on either nibble, zero set.
    wr(OFS_ACC, 32'h01, RESP_OKAY);
    wr(OFS_CMD, cmd(2'h2, 1'b0, 7'h00, 8'h01), RESP_OKAY);
    rd(OFS_ACC, 32'h00, RESP_OKAY, "sub zero acc");
    rd(OFS_STAT, 32'h1F, RESP_OKAY, "sub zero flags");
    // Borrow on both nibbles, wrapping to all ones.
    wr(OFS_ACC, 32'h02, RESP_OKAY);
    wr(OFS_CMD, cmd(2'h2, 1'b0, 7'h00, 8'h01), RESP_OKAY);
    rd(OFS_ACC, 32'hFF, RESP_OKAY, "sub borrow acc");
    rd(OFS_STAT, 32'h18, RESP_OKAY, "sub borrow flags");
    // Left rotate of the top file register into the accumulator.
    wr(fofs(127), 32'hE6, RESP_OKAY);
    wr(OFS_CMD, cmd(2'h1, 1'b0, 7'h7F, 8'h00), RESP_OKAY);
    rd(OFS_ACC, 32'hCC, RESP_OKAY, "rotl acc");
    rd(fofs(127), 32'hE6, RESP_OKAY, "rotl source kept");
    rd(OFS_STAT, 32'h19, RESP_OKAY, "rotl carry");
    // Right rotate back into the file register with carry set.
    wr(fofs(5), 32'h81, RESP_OKAY);
    wr(OFS_CMD, cmd(2'h0, 1'b1, 7'h05, 8'h00), RESP_OKAY);
    rd(fofs(5), 32'hC0, RESP_OKAY, "rotr file");
    rd(OFS_ACC, 32'hCC, RESP_OKAY, "rotr acc kept");
    rd(OFS_STAT, 32'h19, RESP_OKAY, "rotr carry set");
    wr(OFS_CMD, cmd(2'h0, 1'b0, 7'h05, 8'h00), RESP_OKAY);
    rd(OFS_ACC, 32'hE0, RESP_OKAY, "rotr acc");
    rd(OFS_STAT, 32'h18, RESP_OKAY, "rotr carry clear");
    wr(OFS_CMD, cmd(2'h1, 1'b1, 7'h05, 8'h00), RESP_OKAY);
    rd(fofs(5), 32'h80, RESP_OKAY, "rotl file");
    rd(OFS_STAT, 32'h19, RESP_OKAY, "rotl file carry");
    // Sleep freezes execution and clears the watchdog and prescaler.
    wr(OFS_CMD, cmd(2'h3, 1'b0, 7'h00, 8'h00), RESP_OKAY);
    rd(OFS_STAT, 32'h31, RESP_OKAY, "sleep status");
    rd(OFS_WDOG, 32'h0, RESP_OKAY, "sleep watchdog");
    @(negedge CLK);
    chk("sleeping pin", {31'h0, SLEEPING}, 32'h1);
    @(posedge CLK);
    wr(OFS_CMD, cmd(2'h2, 1'b0, 7'h00, 8'h00), RESP_SLVERR);
    rd(OFS_ACC, 32'hE0, RESP_OKAY, "acc kept asleep");
    repeat (300) @(posedge CLK);
    rd(OFS_WDOG, 32'h0, RESP_OKAY, "watchdog frozen");
    WAKE <= 1'b1;
    @(posedge CLK);
    WAKE <= 1'b0;
    @(negedge CLK);
    chk("sleeping after wake", {31'h0, SLEEPING}, 32'h0);
    @(posedge CLK);
    wr(OFS_CMD, cmd(2'h2, 1'b0, 7'h00, 8'hE0), RESP_OKAY);
    rd(OFS_STAT, 32'h17, RESP_OKAY, "flags after wake");
  endtask

  // The whole run takes well under a thousand cycles; the ceiling only cuts a hang.
  initial begin
    fork
      run_tests();
      begin
        repeat (5000) @(posedge CLK);
        bad_count++;
      end
    join_any
    stop_test();
  end
endmodule
